// ---- common/scb_cfg_if.sv ----
`timescale 1ns/10ps
interface scb_cfg_if;
	logic swReset;
	logic pdCtrl;
	logic anEnable;
	logic anDone;
	logic capture;
	logic ready;
	logic pdState;
	logic anStart;
	logic anActive;
	logic linkAttempt;
	modport seq (input swReset, pdCtrl, anEnable, anDone,
		output capture, ready, pdState, anStart, anActive, linkAttempt);
	modport ctl (output swReset, pdCtrl, anEnable, anDone,
		input capture, ready, pdState, anStart, anActive, linkAttempt);
endinterface : scb_cfg_if

// ---- common/scb_pkg.sv ----
package scb_pkg;
	// strap vector layout
	localparam int STRAP_W = 9;
	localparam int SB_TXHI = 0;
	localparam int SB_MACLO = 1;
	localparam int SB_MACHI = 2;
	localparam int SB_PD = 3;
	localparam int SB_LEADER = 4;
	localparam int SB_MEDIA = 5;
	localparam int SB_ADDR = 6;
	localparam int ADDR_W = 3;
	localparam logic [STRAP_W-1:0] STRAP_RST = 9'h000;
	// settle time before straps are sampled
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned SETTLE_NS = 1000;
	localparam int unsigned SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYC - 1);
	// mac interface strap codes, high bit first
	localparam logic [1:0] MACIF_RMII = 2'h0;
	localparam logic [1:0] MACIF_RGMII = 2'h1;
	localparam logic [1:0] MACIF_RSVD = 2'h2;
	localparam logic [1:0] MACIF_MII = 2'h3;
	typedef enum logic [1:0] {MAC_RMII, MAC_RGMII, MAC_MII, MAC_NONE} scb_mac_t;
	typedef enum logic [2:0] {ST_SETTLE, ST_CAPTURE, ST_DECIDE, ST_PDOWN, ST_ANEG, ST_LINK} scb_state_t;
	// management map
	localparam logic [4:0] DEV_PMA = 5'h01;
	localparam logic [4:0] DEV_VEND = 5'h1F;
	localparam logic [4:0] DEV_CTRL = 5'h1E;
	localparam logic [15:0] REG_ID_HIGH = 16'h0002;
	localparam logic [15:0] REG_ID_LOW = 16'h0003;
	localparam logic [15:0] REG_CTRL = 16'h0010;
	localparam logic [15:0] REG_STAT = 16'h0011;
	localparam int C22_W = 5;
	// control and status fields
	localparam int CTRL_PD = 0;
	localparam int CTRL_SRST = 1;
	localparam int CTRL_ANEN = 2;
	localparam int CTRL_TXHIREQ = 3;
	localparam int STAT_RDY = 0;
	localparam int STAT_PD = 1;
	localparam int STAT_HVABLE = 2;
	localparam int STAT_LEADER = 3;
	localparam int STAT_MAC = 4;
	localparam int STAT_MEDIA = 6;
	localparam logic PD_CTRL_RST = 1'b1;
	localparam logic ANEN_RST = 1'b1;
	localparam logic TXHIREQ_RST = 1'b0;
	// identifier low word layout
	localparam int ID2_ORG_LSB = 10;
	localparam int ID2_MODEL_LSB = 4;
	localparam int ID2_REV_LSB = 0;
endpackage : scb_pkg

// ---- test/scb_board_model.sv ----
`timescale 1ns/10ps
module scb_board_model import scb_pkg::*; (
	input wire logic [STRAP_W-1:0] strapCfg,
	input wire logic strapDrive,
	input wire logic [STRAP_W-1:0] pinOut,
	input wire logic [STRAP_W-1:0] pinOeN,
	output logic [STRAP_W-1:0] pinLevel
);
	// device drives while its enable is low, else the strap or the pull-down
	always_comb begin
		for (int b = 0; b < STRAP_W; b++) begin
			pinLevel[b] = !pinOeN[b] ? pinOut[b] : (strapDrive ? strapCfg[b] : 1'b0);
		end
	end
endmodule : scb_board_model

// ---- test/scb_strap_config_bringup_tb.sv ----
`timescale 1ns/10ps
module scb_strap_config_bringup_tb import scb_pkg::*; ();
	localparam logic [15:0] ORG_HI = 16'h4C71; // arbitrary value
	localparam logic [5:0] ORG_LO = 6'h2A; // arbitrary value
	localparam logic [5:0] MODEL = 6'h11; // arbitrary value
	localparam logic [3:0] REV = 4'h6; // arbitrary value
	localparam logic [15:0] ID_LO = {ORG_LO, MODEL, REV};
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [STRAP_W-1:0] strapCfg = '0;
	logic strapDrive = 1'b0;
	logic [STRAP_W-1:0] pinLevel, pinOut, pinOeN;
	logic [STRAP_W-1:0] pinData = '0;
	logic mgmtReq = 1'b0, mgmtWrite = 1'b0, mgmtC45 = 1'b0, anDone = 1'b0;
	logic [4:0] mgmtPhy = '0, mgmtDev = '0, curPhy = '0;
	logic [15:0] mgmtReg = '0, mgmtWr = '0, mgmtRdData;
	logic mgmtAck, mediaEn, leaderPref, hvAble, hvTxEn, pdActive, sysRdy, anEn, anStart, anActive, linkTry;
	logic [ADDR_W-1:0] phyAddr;
	scb_mac_t macIfMode;
	int err_total = 0;
	int check_count = 0;
	int anStarts = 0;
	logic [STRAP_W-1:0] cfgTab [5] = '{9'h000, 9'h17B, 9'h0A4, 9'h1CF, 9'h0F8};

	scb_strap_config_bringup #(.ID_ORG_HIGH(ORG_HI), .ID_ORG_LOW(ORG_LO), .ID_MODEL(MODEL), .ID_REV(REV))
	i_scb_strap_config_bringup (
		.ref_clk(ref_clk), .rst_n(rst_n), .strapPinIn(pinLevel), .strapPinOut(pinOut), .strapPinOeN(pinOeN),
		.pinDataIn(pinData), .mgmtReq(mgmtReq), .mgmtWrite(mgmtWrite), .mgmtC45(mgmtC45),
		.mgmtPhyAddr(mgmtPhy), .mgmtDevAddr(mgmtDev), .mgmtRegAddr(mgmtReg), .mgmtWrData(mgmtWr),
		.mgmtAck(mgmtAck), .mgmtRdData(mgmtRdData), .anDone(anDone), .phyAddr(phyAddr), .macIfMode(macIfMode),
		.mediaConverterEn(mediaEn), .leaderPreferred(leaderPref), .highVoltageAbility(hvAble),
		.highLevelTxEn(hvTxEn), .powerdownActive(pdActive), .systemReady(sysRdy), .anEnabled(anEn),
		.anStart(anStart), .anActive(anActive), .linkAttempt(linkTry));

	scb_board_model i_scb_board_model (.strapCfg(strapCfg), .strapDrive(strapDrive), .pinOut(pinOut),
		.pinOeN(pinOeN), .pinLevel(pinLevel));

	// counts autonegotiation start pulses, each stands one full cycle
	always @(negedge ref_clk) begin
		if (anStart === 1'b1) anStarts++;
	end

	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic print_verdict();
		if (err_total == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic chkb(input string name, input logic seen, input logic exp);
		check(name, {15'h0000, seen}, {15'h0000, exp});
	endtask : chkb

	// one-cycle request, answer sampled once the acknowledge shows
	task automatic mgmt(input logic wr, input logic c45, input logic [4:0] dev, input logic [15:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		int n;
		@(negedge ref_clk);
		{mgmtReq, mgmtWrite, mgmtC45, mgmtPhy, mgmtDev, mgmtReg, mgmtWr} = {1'b1, wr, c45, curPhy, dev, ra, wd};
		@(negedge ref_clk);
		mgmtReq = 1'b0;
		for (n = 0; n < 3 && mgmtAck !== 1'b1; n++) @(negedge ref_clk);
		chkb("mgmtAck", mgmtAck, 1'b1);
		rd = mgmtRdData;
	endtask : mgmt

	task automatic rdchk(input string name, input logic c45, input logic [4:0] dev, input logic [15:0] ra,
		input logic [15:0] exp);
		logic [15:0] v;
		mgmt(1'b0, c45, dev, ra, 16'h0000, v);
		check(name, v, exp);
	endtask : rdchk

	task automatic wrctl(input logic [15:0] wd);
		logic [15:0] v;
		mgmt(1'b1, 1'b1, DEV_CTRL, REG_CTRL, wd, v);
		repeat (2) @(negedge ref_clk);
	endtask : wrctl

	function automatic logic [1:0] macExp(input logic [1:0] c);
		return (c == MACIF_RMII) ? MAC_RMII : (c == MACIF_RGMII) ? MAC_RGMII : (c == MACIF_MII) ? MAC_MII : MAC_NONE;
	endfunction : macExp

	initial begin
		#200000;
		err_total++;
		$display("[FAIL] watchdog expected done seen timeout");
		print_verdict();
	end

	initial begin
		logic [15:0] v;
		logic [STRAP_W-1:0] c;
		int n;
		for (int i = 0; i < 5; i++) begin
			c = cfgTab[i];
			@(negedge ref_clk);
			strapCfg = c;
			strapDrive = (i != 0);
			if (i % 2 == 0) begin
				rst_n = 1'b0;
				repeat (10) @(negedge ref_clk);
				check("oeReset", {7'h00, pinOeN}, 16'h01FF);
				rst_n = 1'b1;
				curPhy = 5'h00;
				rdchk("idEarly", 1'b0, 5'h00, REG_ID_HIGH, 16'h0000);
			end else begin
				wrctl(16'h0002);
				chkb("rdyDrop", sysRdy, 1'b0);
			end
			for (n = 0; n < 400 && sysRdy !== 1'b1; n++) @(negedge ref_clk);
			chkb("sysRdy", sysRdy, 1'b1);
			curPhy = {2'b00, c[SB_ADDR+:ADDR_W]};
			check("phyAddr", {13'h0000, phyAddr}, {13'h0000, c[SB_ADDR+:ADDR_W]});
			check("macIfMode", {14'h0000, macIfMode}, {14'h0000, macExp(c[SB_MACHI:SB_MACLO])});
			chkb("hvAble", hvAble, !c[SB_TXHI]);
			chkb("hvTxEn", hvTxEn, !c[SB_TXHI]);
			chkb("leader", leaderPref, c[SB_LEADER]);
			chkb("media", mediaEn, c[SB_MEDIA] && c[SB_MACHI:SB_MACLO] == MACIF_RMII);
			chkb("pdown", pdActive, !c[SB_PD]);
			chkb("anEn", anEn, 1'b1);
			rdchk("idHi22", 1'b0, 5'h00, REG_ID_HIGH, ORG_HI);
			rdchk("idLo22", 1'b0, 5'h00, REG_ID_LOW, ID_LO);
			rdchk("idHi45", 1'b1, DEV_PMA, REG_ID_HIGH, ORG_HI);
			rdchk("idLo45", 1'b1, DEV_VEND, REG_ID_LOW, ID_LO);
			mgmt(1'b0, 1'b1, DEV_CTRL, REG_STAT, 16'h0000, v);
			check("stat", v & 16'h003F, {10'h000, c[SB_MACHI:SB_MACLO], c[SB_LEADER], !c[SB_TXHI], !c[SB_PD], 1'b1});
			rdchk("unmapped", 1'b1, DEV_CTRL, 16'h0012, 16'h0000);
			curPhy ^= 5'h10;
			rdchk("wrongPhy", 1'b0, 5'h00, REG_ID_HIGH, 16'h0000);
			curPhy ^= 5'h10;
			check("oeRun", {7'h00, pinOeN}, 16'h0000);
			pinData = ~c;
			repeat (4) @(negedge ref_clk);
			check("pinOut", {7'h00, pinOut}, {7'h00, ~c});
			check("addrHeld", {13'h0000, phyAddr}, {13'h0000, c[SB_ADDR+:ADDR_W]});
			if (c[SB_PD]) begin
				chkb("anActive", anActive, 1'b1);
			end else begin
				repeat (40) @(negedge ref_clk);
				chkb("pdHold", pdActive, 1'b1);
				chkb("anIdle", anActive, 1'b0);
				wrctl(16'h0004);
				chkb("pdExit", pdActive, 1'b0);
				chkb("anAfterPd", anActive, 1'b1);
			end
			anDone = 1'b1;
			for (n = 0; n < 20 && linkTry !== 1'b1; n++) @(negedge ref_clk);
			chkb("link", linkTry, 1'b1);
			check("anStarts", 16'(anStarts), 16'(i + 1));
			anDone = 1'b0;
			wrctl(16'h000C);
			chkb("txReq", hvTxEn, !c[SB_TXHI]);
			wrctl(16'h0004);
			chkb("txLow", hvTxEn, 1'b0);
		end
		print_verdict();
	end
endmodule : scb_strap_config_bringup_tb

// ---- verilog/scb_seq.sv ----
`timescale 1ns/10ps
module scb_seq import scb_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst_n,
	scb_cfg_if.seq cfg
);
	scb_state_t state_q;
	scb_state_t state_d;
	logic [7:0] cnt_q;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_SETTLE: if (cnt_q == SETTLE_LAST) state_d = ST_CAPTURE;
			ST_CAPTURE: state_d = ST_DECIDE;
			ST_DECIDE, ST_PDOWN: begin
				if (cfg.pdCtrl) state_d = ST_PDOWN;
				else if (cfg.anEnable) state_d = ST_ANEG;
				else state_d = ST_LINK;
			end
			ST_ANEG: begin
				if (cfg.pdCtrl) state_d = ST_PDOWN;
				else if (!cfg.anEnable || cfg.anDone) state_d = ST_LINK;
			end
			ST_LINK: if (cfg.pdCtrl) state_d = ST_PDOWN;
			default: state_d = ST_SETTLE;
		endcase
		if (cfg.swReset) state_d = ST_SETTLE;
	end

	assign cfg.capture = (state_q == ST_CAPTURE);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) state_q <= ST_SETTLE;
		else state_q <= state_d;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) cnt_q <= '0;
		else if (state_d == ST_SETTLE && state_q == ST_SETTLE) cnt_q <= cnt_q + 8'h01;
		else cnt_q <= '0;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg.ready <= 1'b0;
			cfg.pdState <= 1'b0;
			cfg.anStart <= 1'b0;
			cfg.anActive <= 1'b0;
			cfg.linkAttempt <= 1'b0;
		end else begin
			cfg.ready <= !(state_d inside {ST_SETTLE, ST_CAPTURE, ST_DECIDE});
			cfg.pdState <= (state_d == ST_PDOWN);
			cfg.anStart <= (state_d == ST_ANEG) && (state_q != ST_ANEG);
			cfg.anActive <= (state_d == ST_ANEG);
			cfg.linkAttempt <= (state_d == ST_LINK);
		end
	end
endmodule : scb_seq

// ---- verilog/scb_strap_config_bringup.sv ----
`timescale 1ns/10ps
// Contract
// - low amplitude strap enables high-voltage mode, ability 1
// - high amplitude strap disables high-voltage, ability 0
// - ability bit reports 2.4 V support
// - mac strap 00 RMII, 01 RGMII, 11 MII
// - floating mac straps default to RMII
// - unmanaged, no power-down: autonegotiate then link
// - power-down without management access persists
// - leader strap sets advertised leader/follower preference
// - media converter strap works only in RMII
// - three address straps give management address
// - managed power-down waits for software activation
// - identifiers at 0x2/0x3, clause 22 and 45
// - identifier words hold org id, model, revision
// - identifiers read wrong until start-up completes
// - system-ready bit shows start-up complete
// - power-down status bit, strap influenced
// - autonegotiation enabled by default after reset
// - both levels allowed only with ability set
// - low power-down strap enters power-down after reset
// - leader strap low prefers follower, high leader
// - writing power-down control 0 exits power-down
// - eight addresses, floating pins give zero
module scb_strap_config_bringup import scb_pkg::*; #(
	parameter logic [15:0] ID_ORG_HIGH = 16'h1A2B, // arbitrary value
	parameter logic [5:0] ID_ORG_LOW = 6'h15, // arbitrary value
	parameter logic [5:0] ID_MODEL = 6'h0C, // arbitrary value
	parameter logic [3:0] ID_REV = 4'h3 // arbitrary value
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [STRAP_W-1:0] strapPinIn,
	output logic [STRAP_W-1:0] strapPinOut,
	output logic [STRAP_W-1:0] strapPinOeN,
	input wire logic [STRAP_W-1:0] pinDataIn,
	input wire logic mgmtReq,
	input wire logic mgmtWrite,
	input wire logic mgmtC45,
	input wire logic [4:0] mgmtPhyAddr,
	input wire logic [4:0] mgmtDevAddr,
	input wire logic [15:0] mgmtRegAddr,
	input wire logic [15:0] mgmtWrData,
	output logic mgmtAck,
	output logic [15:0] mgmtRdData,
	input wire logic anDone,
	output logic [ADDR_W-1:0] phyAddr,
	output scb_mac_t macIfMode,
	output logic mediaConverterEn,
	output logic leaderPreferred,
	output logic highVoltageAbility,
	output logic highLevelTxEn,
	output logic powerdownActive,
	output logic systemReady,
	output logic anEnabled,
	output logic anStart,
	output logic anActive,
	output logic linkAttempt
);
	scb_cfg_if cfg();
	logic [STRAP_W-1:0] strapSync;
	logic [STRAP_W-1:0] strap_q;
	logic pdCtrl_q;
	logic anEn_q;
	logic txHiReq_q;
	logic swReset_q;
	logic [1:0] macCode;
	scb_mac_t macDecode;
	logic addrHit;
	logic c22Ok;
	logic selIdHigh;
	logic selIdLow;
	logic selCtrl;
	logic selStat;
	logic ctrlWr;
	logic [15:0] idLowWord;
	logic [15:0] statWord;
	logic [15:0] rdMux;

	scb_strap_sync #(.W(STRAP_W)) uSync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.din(strapPinIn),
		.dout(strapSync)
	);

	scb_seq uSeq (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.cfg(cfg.seq)
	);

	assign cfg.swReset = swReset_q;
	assign cfg.pdCtrl = pdCtrl_q;
	assign cfg.anEnable = anEn_q;
	assign cfg.anDone = anDone;
	assign systemReady = cfg.ready;
	assign powerdownActive = cfg.pdState;
	assign anStart = cfg.anStart;
	assign anActive = cfg.anActive;
	assign linkAttempt = cfg.linkAttempt;

	// strap capture; pull-down reset value stands for floating pins
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) strap_q <= STRAP_RST;
		else if (cfg.capture) strap_q <= strapSync;
	end

	// shared pins are released while sampling, then driven with user data
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			strapPinOeN <= '1;
			strapPinOut <= '0;
		end else begin
			strapPinOeN <= cfg.ready ? '0 : '1;
			strapPinOut <= pinDataIn;
		end
	end

	assign macCode = {strap_q[SB_MACHI], strap_q[SB_MACLO]};

	always_comb begin
		unique case (macCode)
			MACIF_RMII: macDecode = MAC_RMII;
			MACIF_RGMII: macDecode = MAC_RGMII;
			MACIF_MII: macDecode = MAC_MII;
			MACIF_RSVD: macDecode = MAC_NONE;
		endcase
	end

	// decoded configuration outputs
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phyAddr <= '0;
			macIfMode <= MAC_RMII;
			mediaConverterEn <= 1'b0;
			leaderPreferred <= 1'b0;
			highVoltageAbility <= 1'b0;
			highLevelTxEn <= 1'b0;
			anEnabled <= ANEN_RST;
		end else begin
			phyAddr <= strap_q[SB_ADDR +: ADDR_W];
			macIfMode <= macDecode;
			mediaConverterEn <= strap_q[SB_MEDIA] && (macDecode == MAC_RMII);
			leaderPreferred <= strap_q[SB_LEADER];
			highVoltageAbility <= !strap_q[SB_TXHI];
			highLevelTxEn <= !strap_q[SB_TXHI] && txHiReq_q;
			anEnabled <= anEn_q;
		end
	end

	// management decode
	assign addrHit = (mgmtPhyAddr == {2'b00, strap_q[SB_ADDR +: ADDR_W]});
	assign c22Ok = !mgmtC45 && (mgmtRegAddr[15:C22_W] == '0);
	assign selIdHigh = (c22Ok && mgmtRegAddr[C22_W-1:0] == REG_ID_HIGH[C22_W-1:0])
		|| (mgmtC45 && (mgmtDevAddr == DEV_PMA || mgmtDevAddr == DEV_VEND) && mgmtRegAddr == REG_ID_HIGH);
	assign selIdLow = (c22Ok && mgmtRegAddr[C22_W-1:0] == REG_ID_LOW[C22_W-1:0])
		|| (mgmtC45 && (mgmtDevAddr == DEV_PMA || mgmtDevAddr == DEV_VEND) && mgmtRegAddr == REG_ID_LOW);
	assign selCtrl = mgmtC45 && mgmtDevAddr == DEV_CTRL && mgmtRegAddr == REG_CTRL;
	assign selStat = mgmtC45 && mgmtDevAddr == DEV_CTRL && mgmtRegAddr == REG_STAT;
	assign ctrlWr = mgmtReq && mgmtWrite && addrHit && selCtrl;
	assign idLowWord = {ID_ORG_LOW, ID_MODEL, ID_REV};

	always_comb begin
		statWord = '0;
		statWord[STAT_RDY] = cfg.ready;
		statWord[STAT_PD] = cfg.pdState;
		statWord[STAT_HVABLE] = highVoltageAbility;
		statWord[STAT_LEADER] = leaderPreferred;
		statWord[STAT_MAC +: 2] = macCode;
		statWord[STAT_MEDIA] = mediaConverterEn;
	end

	always_comb begin
		rdMux = '0;
		if (selIdHigh && cfg.ready) rdMux = ID_ORG_HIGH;
		else if (selIdLow && cfg.ready) rdMux = idLowWord;
		else if (selCtrl) begin
			rdMux[CTRL_PD] = pdCtrl_q;
			rdMux[CTRL_ANEN] = anEn_q;
			rdMux[CTRL_TXHIREQ] = txHiReq_q;
		end else if (selStat) rdMux = statWord;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mgmtAck <= 1'b0;
			mgmtRdData <= '0;
		end else begin
			mgmtAck <= mgmtReq;
			if (mgmtReq) mgmtRdData <= (!mgmtWrite && addrHit) ? rdMux : '0;
		end
	end

	// power-down control: strap sample wins over a write in the same cycle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) pdCtrl_q <= PD_CTRL_RST;
		else if (cfg.capture) pdCtrl_q <= !strapSync[SB_PD];
		else if (ctrlWr) pdCtrl_q <= mgmtWrData[CTRL_PD];
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) anEn_q <= ANEN_RST;
		else if (cfg.capture) anEn_q <= ANEN_RST;
		else if (ctrlWr) anEn_q <= mgmtWrData[CTRL_ANEN];
	end

	// high-level request only sticks when the ability is present
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) txHiReq_q <= TXHIREQ_RST;
		else if (cfg.capture) txHiReq_q <= !strapSync[SB_TXHI];
		else if (ctrlWr) txHiReq_q <= mgmtWrData[CTRL_TXHIREQ] && !strap_q[SB_TXHI];
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) swReset_q <= 1'b0;
		else swReset_q <= ctrlWr && mgmtWrData[CTRL_SRST];
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence capLowAmp;
		cfg.capture && !strapSync[SB_TXHI];
	endsequence

	sequence capHighAmp;
		cfg.capture && strapSync[SB_TXHI];
	endsequence

	sequence pdExitWrite;
		ctrlWr && !mgmtWrData[CTRL_PD] && !mgmtWrData[CTRL_SRST] && cfg.pdState && !cfg.capture;
	endsequence

	AST_HV_ENABLE: assert property (capLowAmp |-> ##2 highVoltageAbility && highLevelTxEn)
		else $error("low amplitude strap did not enable high voltage");

	AST_HV_DISABLE: assert property (capHighAmp |-> ##2 !highVoltageAbility && !highLevelTxEn)
		else $error("high amplitude strap left high voltage on");

	AST_MAC_MII: assert property (cfg.capture && {strapSync[SB_MACHI], strapSync[SB_MACLO]} == MACIF_MII
		|-> ##2 macIfMode == MAC_MII)
		else $error("mac strap 11 did not select MII");

	AST_MAC_RSVD: assert property (cfg.capture && {strapSync[SB_MACHI], strapSync[SB_MACLO]} == MACIF_RSVD
		|-> ##2 macIfMode == MAC_NONE && !mediaConverterEn)
		else $error("reserved mac code enabled an interface");

	AST_MEDIA_RMII: assert property (mediaConverterEn |-> macIfMode == MAC_RMII)
		else $error("media converter outside RMII");

	AST_ADDR: assert property (cfg.capture |-> ##2 phyAddr == $past(strapSync[SB_ADDR +: ADDR_W], 2))
		else $error("address does not follow straps");

	AST_PD_STAY: assert property (powerdownActive && !ctrlWr && !$past(ctrlWr) && !swReset_q |=> powerdownActive)
		else $error("power-down left without management access");

	AST_PD_EXIT: assert property (pdExitWrite |-> ##2 !powerdownActive)
		else $error("writing zero did not leave power-down");

	AST_PD_STRAP: assert property (cfg.capture && !strapSync[SB_PD] |-> ##2 powerdownActive[*3])
		else $error("low power-down strap did not power down");

	AST_ID_GATE: assert property (mgmtAck && !$past(cfg.ready) |-> mgmtRdData != ID_ORG_HIGH
		|| ID_ORG_HIGH == '0)
		else $error("identifier readable before start-up");

	AST_HV_TX: assert property (highLevelTxEn |-> highVoltageAbility)
		else $error("high level allowed without ability");

	AST_AN_START: assert property (anStart |-> anActive && !powerdownActive ##1 !anStart)
		else $error("autonegotiation start malformed");

	AST_PINS_FREE: assert property ($rose(systemReady) |=> strapPinOeN == '0)
		else $error("pins not driven after start-up");
endmodule : scb_strap_config_bringup

// ---- verilog/scb_strap_sync.sv ----
`timescale 1ns/10ps
module scb_strap_sync #(
	parameter int W = 1
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			dout <= '0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule : scb_strap_sync
